// file: core/adc_link_pkg.sv
// Contract
// RULE1 - hold input at rising sample clock
// RULE2 - capture may use rising sample clock
// RULE3 - power down stops and floats outputs
// RULE4 - dither added only while enabled
// RULE5 - sixteen bit word, bit fifteen MSB
// RULE6 - negative valid toggles, latch on fall
// RULE7 - positive valid inverse, latch on rise
// RULE8 - range flag high when out of range
// RULE9 - output enable low drives outputs
// RULE10 - four level format and stabilizer select
// RULE11 - scramble XORs bits one-fifteen with bit zero
// RULE12 - receiver XORs LSB back to decode
// RULE13 - gain select scales input range
// RULE14 - word appears seven sample cycles later
// RULE15 - five stage results aligned then combined
// RULE16 - twos complement inverts MSB before scramble
package adc_link_pkg;
  localparam int SAMPLE_WIDTH = 16;
  localparam int ANALOG_WIDTH = 18;
  localparam int LATENCY_CYCLES = 7;
  localparam int PIPE_STAGES = 5;
  // stage 0 resolves the top four bits, later stages three each
  localparam logic [PIPE_STAGES-1:0][15:0] STAGE_MASK =
    {16'h0007, 16'h0038, 16'h01C0, 16'h0E00, 16'hF000};
  localparam logic signed [19:0] CODE_MIDSCALE = 20'sh08000;
  localparam logic signed [19:0] CODE_TOP = 20'sh0FFFF;
  localparam logic [14:0] LFSR_SEED = 15'h0001;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    FMT_OFFSET_NOSTAB,
    FMT_OFFSET_STAB,
    FMT_TWOS_STAB,
    FMT_TWOS_NOSTAB
  } format_t;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] DATA_OFFSET = 8'h0C;
  localparam int CTRL_POWER_DOWN = 0;
  localparam int CTRL_DITHER = 1;
  localparam int CTRL_SCRAMBLE = 2;
  localparam int CTRL_GAIN = 3;
  localparam int CTRL_OUT_DISABLE = 4;
  localparam int CTRL_FORMAT_LO = 5;
  localparam int CTRL_CAPTURE_ON_CLOCK = 7;
  localparam int EVT_WORD = 0;
  localparam int EVT_RANGE = 1;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: core/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  logic sampleClockP;
  logic sampleClockN;
  logic powerDown;
  logic noiseInjectEnable;
  logic outputScrambleEnable;
  logic gainSelect;
  logic outputEnableN;
  logic [1:0] formatSelect;
  logic [15:0] sampleWord;
  logic sampleWordOe;
  logic dataValidP;
  logic dataValidN;
  logic rangeFlag;

  modport device (
    input sampleClockP, sampleClockN, powerDown, noiseInjectEnable,
    input outputScrambleEnable, gainSelect, outputEnableN, formatSelect,
    output sampleWord, sampleWordOe, dataValidP, dataValidN, rangeFlag
  );

  modport capture (
    output sampleClockP, sampleClockN, powerDown, noiseInjectEnable,
    output outputScrambleEnable, gainSelect, outputEnableN, formatSelect,
    input sampleWord, sampleWordOe, dataValidP, dataValidN, rangeFlag
  );
endinterface

// file: core/adc_device_end.sv
`timescale 1ns/1ps
module adc_device_end (
  adc_link_if.device link,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [adc_link_pkg::ANALOG_WIDTH-1:0] analogIn,
  output logic [15:0] heldCode,
  output logic heldOverRange,
  output logic stabilizerOn,
  output logic twosComplement,
  output logic poweredDown,
  output logic ditherActive
);
  import adc_link_pkg::*;

  typedef struct packed {
    logic [1:0] encP;
    logic [1:0] encN;
    logic encPrev;
    logic [1:0] pd;
    logic [1:0] noise_inject_enable;
    logic [1:0] scr;
    logic [1:0] gain;
    logic [1:0] oeN;
    logic [1:0][1:0] fmt;
    logic [14:0] lfsr;
    logic [LATENCY_CYCLES-1:0][15:0] resid;
    logic [LATENCY_CYCLES-1:0][15:0] bits;
    logic [LATENCY_CYCLES-1:0] ovf;
    logic [15:0] held;
    logic heldOvf;
    logic [15:0] word;
    logic flag;
    logic dvN;
    logic dvP;
    logic oe;
    logic stab;
    logic twos;
  } dev_state_t;

  dev_state_t s;
  dev_state_t n;

  logic encHigh;
  logic rise;
  logic fall;
  logic pdNow;
  format_t fmt;
  logic signed [19:0] ext;
  logic signed [19:0] scaled;
  logic signed [19:0] noise_inject_enable;
  logic signed [19:0] biased;
  logic overRange;
  logic [15:0] code;
  logic [15:0] corrected;
  logic [15:0] formatted;

  always_comb begin
    n = s;
    // first flops feed only the second ones
    n.encP = {s.encP[0], link.sampleClockP};
    n.encN = {s.encN[0], link.sampleClockN};
    n.pd = {s.pd[0], link.powerDown};
    n.noise_inject_enable = {s.noise_inject_enable[0], link.noiseInjectEnable};
    n.scr = {s.scr[0], link.outputScrambleEnable};
    n.gain = {s.gain[0], link.gainSelect};
    n.oeN = {s.oeN[0], link.outputEnableN};
    n.fmt = {s.fmt[0], link.formatSelect};

    // RULE1 differential edge detect
    encHigh = s.encP[1] & ~s.encN[1];
    n.encPrev = encHigh;
    rise = encHigh & ~s.encPrev;
    fall = ~encHigh & s.encPrev;
    pdNow = s.pd[1];
    fmt = format_t'(s.fmt[1]);

    // RULE10 format and stabilizer decode
    n.twos = (fmt == FMT_TWOS_STAB) || (fmt == FMT_TWOS_NOSTAB);
    n.stab = (fmt == FMT_OFFSET_STAB) || (fmt == FMT_TWOS_STAB);

    // RULE13 gain of one or one and a half
    ext = {{(20 - ANALOG_WIDTH){analogIn[ANALOG_WIDTH-1]}}, analogIn};
    scaled = s.gain[1] ? ext + (ext >>> 1) : ext;
    // RULE4 dither only while enabled
    noise_inject_enable = s.noise_inject_enable[1] ? $signed({{18{s.lfsr[1]}}, s.lfsr[1:0]}) : 20'sh00000;
    biased = scaled + noise_inject_enable + CODE_MIDSCALE;
    // RULE8 range check at quantization
    overRange = biased[19] || (biased > CODE_TOP);
    if (biased[19]) begin
      code = 16'h0000;
    end else if (biased > CODE_TOP) begin
      code = 16'hFFFF;
    end else begin
      code = biased[15:0];
    end

    corrected = s.bits[LATENCY_CYCLES-1];
    // RULE16 invert MSB ahead of scrambling
    formatted = s.twos ? {~corrected[15], corrected[14:0]} : corrected;
    // RULE11 scramble upper bits with LSB
    if (s.scr[1]) begin
      formatted = {formatted[15:1] ^ {15{formatted[0]}}, formatted[0]};
    end

    // RULE3 analog side frozen while powered down
    if (rise && !pdNow) begin
      // RULE1 hold on the rising edge
      n.held = code;
      n.heldOvf = overRange;
      if (s.noise_inject_enable[1]) begin
        n.lfsr = {s.lfsr[13:0], s.lfsr[14] ^ s.lfsr[13]};
      end
      // RULE14 seven slot shift per sample
      n.resid[0] = code;
      n.bits[0] = 16'h0000;
      n.ovf[0] = overRange;
      for (int i = 1; i < LATENCY_CYCLES; i++) begin
        n.resid[i] = s.resid[i-1];
        n.bits[i] = s.bits[i-1];
        n.ovf[i] = s.ovf[i-1];
        // RULE15 stage result moved into aligned word
        if (i <= PIPE_STAGES) begin
          n.bits[i] = s.bits[i-1] | (s.resid[i-1] & STAGE_MASK[i-1]);
          n.resid[i] = s.resid[i-1] & ~STAGE_MASK[i-1];
        end
      end
      // RULE5 parallel word out
      n.word = formatted;
      n.flag = s.ovf[LATENCY_CYCLES-1];
    end

    // RULE6 RULE7 valid pair follows sample clock
    if (rise) begin
      n.dvN = 1'b1;
      n.dvP = 1'b0;
    end else if (fall) begin
      n.dvN = 1'b0;
      n.dvP = 1'b1;
    end

    // RULE9 RULE3 drivers on only when enabled and awake
    n.oe = ~pdNow & ~s.oeN[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.lfsr <= LFSR_SEED;
      s.dvP <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.sampleWord = s.word;
  assign link.rangeFlag = s.flag;
  assign link.dataValidN = s.dvN;
  assign link.dataValidP = s.dvP;
  assign link.sampleWordOe = s.oe;
  assign heldCode = s.held;
  assign heldOverRange = s.heldOvf;
  assign stabilizerOn = s.stab;
  assign twosComplement = s.twos;
  assign poweredDown = s.pd[1];
  assign ditherActive = s.noise_inject_enable[1];
endmodule

// file: core/adc_capture_end.sv
`timescale 1ns/1ps
module adc_capture_end #(
  parameter int HALF_CYCLES = adc_link_pkg::LINK_HALF_CYCLES
) (
  adc_link_if.capture link,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] capturedWord,
  output logic capturedFlag,
  output logic capturedValid,
  output logic irq
);
  import adc_link_pkg::*;

  typedef struct packed {
    logic [7:0] div;
    logic clkP;
    logic [1:0] dvS;
    logic dvPrev;
    logic [1:0][15:0] wordS;
    logic [1:0] flagS;
    logic [31:0] ctrl;
    logic [31:0] status;
    logic [31:0] mask;
    logic [15:0] capWord;
    logic capFlag;
    logic capValid;
    logic irq;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cap_state_t;

  cap_state_t s;
  cap_state_t n;
  logic ownRise;
  logic dvRise;
  logic take;
  logic [15:0] decoded;
  logic [31:0] setBits;
  logic [31:0] clrBits;

  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = data[8*b +: 8];
    end
    return r;
  endfunction

  always_comb begin
    n = s;
    n.capValid = 1'b0;
    setBits = 32'h00000000;
    clrBits = 32'h00000000;

    // sample clock made by dividing the local clock
    ownRise = 1'b0;
    if (s.div == 8'(HALF_CYCLES - 1)) begin
      n.div = 8'h00;
      n.clkP = ~s.clkP;
      ownRise = ~s.clkP;
    end else begin
      n.div = s.div + 8'h01;
    end

    n.dvS = {s.dvS[0], link.dataValidP};
    n.wordS = {s.wordS[0], link.sampleWord};
    n.flagS = {s.flagS[0], link.rangeFlag};
    n.dvPrev = s.dvS[1];
    // RULE7 latch on rising positive valid
    dvRise = s.dvS[1] & ~s.dvPrev;
    // RULE2 alternative capture on own sample clock edge
    take = s.ctrl[CTRL_CAPTURE_ON_CLOCK] ? ownRise : dvRise;
    // RULE12 undo scrambling with the LSB
    decoded = s.wordS[1];
    if (s.ctrl[CTRL_SCRAMBLE]) begin
      decoded = {decoded[15:1] ^ {15{decoded[0]}}, decoded[0]};
    end
    if (take) begin
      n.capWord = decoded;
      n.capFlag = s.flagS[1];
      n.capValid = 1'b1;
      setBits[EVT_WORD] = 1'b1;
      setBits[EVT_RANGE] = s.flagS[1];
    end

    if (awvalid && s.awready) begin
      n.awAddr = awaddr;
      n.awHeld = 1'b1;
      n.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      n.wData = wdata;
      n.wStrb = wstrb;
      n.wHeld = 1'b1;
      n.wready = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (s.awAddr)
        CTRL_OFFSET: n.ctrl = laneMerge(s.ctrl, s.wData, s.wStrb);
        STATUS_OFFSET: clrBits = laneMerge(32'h00000000, s.wData, s.wStrb);
        MASK_OFFSET: n.mask = laneMerge(s.mask, s.wData, s.wStrb);
        DATA_OFFSET: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case (araddr)
        CTRL_OFFSET: n.rdata = s.ctrl;
        STATUS_OFFSET: n.rdata = s.status;
        MASK_OFFSET: n.rdata = s.mask;
        DATA_OFFSET: n.rdata = {15'h0000, s.capFlag, s.capWord};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // a new event beats a clear in the same cycle
    n.status = ((s.status & ~clrBits) | setBits) & 32'h00000003;
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.status <= STATUS_RESET;
      s.mask <= MASK_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      // valid idles high out of reset; a low start would fake a capture
      s.dvS <= 2'h3;
      s.dvPrev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.sampleClockP = s.clkP;
  assign link.sampleClockN = ~s.clkP;
  assign link.powerDown = s.ctrl[CTRL_POWER_DOWN];
  assign link.noiseInjectEnable = s.ctrl[CTRL_DITHER];
  assign link.outputScrambleEnable = s.ctrl[CTRL_SCRAMBLE];
  assign link.gainSelect = s.ctrl[CTRL_GAIN];
  assign link.outputEnableN = s.ctrl[CTRL_OUT_DISABLE];
  assign link.formatSelect = s.ctrl[CTRL_FORMAT_LO +: 2];
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign capturedWord = s.capWord;
  assign capturedFlag = s.capFlag;
  assign capturedValid = s.capValid;
  assign irq = s.irq;
endmodule

// file: verification/adc_link_props.sv
`timescale 1ns/1ps
module adc_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sampleClockP,
  input wire logic sampleClockN,
  input wire logic powerDown,
  input wire logic outputEnableN,
  input wire logic [15:0] sampleWord,
  input wire logic sampleWordOe,
  input wire logic dataValidP,
  input wire logic dataValidN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_clk_pair; sampleClockN == !sampleClockP; endproperty
  a_clk_pair: assert property (p_clk_pair)
    else $error("sample clock pair not complementary");

  property p_valid_pair; dataValidP == !dataValidN; endproperty
  a_valid_pair: assert property (p_valid_pair)
    else $error("valid pair not complementary");

  property p_rise_valid; $rose(sampleClockP) |-> ##[1:4] $rose(dataValidN); endproperty
  a_rise_valid: assert property (p_rise_valid)
    else $error("valid did not follow sample clock rise");

  property p_fall_valid; $fell(sampleClockP) |-> ##[1:4] $fell(dataValidN); endproperty
  a_fall_valid: assert property (p_fall_valid)
    else $error("valid did not follow sample clock fall");

  property p_valid_hold; $rose(dataValidN) |-> dataValidN [*3]; endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("valid high phase too short");

  // the word may only move together with a rising dataValidN edge, never mid-period
  property p_word_step;
    sampleWordOe && $past(sampleWordOe) && $changed(sampleWord) |-> $rose(dataValidN);
  endproperty
  a_word_step: assert property (p_word_step)
    else $error("word changed away from valid edge");

  property p_pd_float; powerDown [*4] |-> !sampleWordOe; endproperty
  a_pd_float: assert property (p_pd_float)
    else $error("outputs driven while powered down");

  property p_oe_float; outputEnableN [*4] |-> !sampleWordOe; endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("outputs driven while disabled");

  property p_oe_drive; (!outputEnableN && !powerDown) [*5] |-> sampleWordOe; endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("outputs not driven while enabled");
endmodule

// file: verification/test_pipelined_adc_output_control.sv
`timescale 1ns/1ps
module test_pipelined_adc_output_control;
  import adc_link_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [ANALOG_WIDTH-1:0] analogIn = '0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] capturedWord, heldCode;
  logic capturedFlag, capturedValid, heldOverRange;
  logic stabilizerOn, twosComplement, poweredDown, ditherActive;
  logic [31:0] seed = 32'h2928;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  adc_link_if link();
  adc_device_end u_adc_device_end (.link(link), .clk(clk), .rst_n(rst_n),
    .analogIn(analogIn), .heldCode(heldCode), .heldOverRange(heldOverRange),
    .stabilizerOn(stabilizerOn), .twosComplement(twosComplement),
    .poweredDown(poweredDown), .ditherActive(ditherActive));
  adc_capture_end u_adc_capture_end (.link(link), .clk(clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capturedWord(capturedWord), .capturedFlag(capturedFlag),
    .capturedValid(capturedValid), .irq(irq));
  adc_link_props u_adc_link_props (.clk(clk), .rst_n(rst_n),
    .sampleClockP(link.sampleClockP), .sampleClockN(link.sampleClockN),
    .powerDown(link.powerDown), .outputEnableN(link.outputEnableN),
    .sampleWord(link.sampleWord), .sampleWordOe(link.sampleWordOe),
    .dataValidP(link.dataValidP), .dataValidN(link.dataValidN));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ideal converter: clamps at both ends of the code range
  function automatic logic [15:0] expCode(input int a, input logic g);
    int c;
    c = (g ? a * 3 / 2 : a) + 32768;
    if (c > 65535) c = 65535;
    if (c < 0) c = 0;
    return c[15:0];
  endfunction

  function automatic logic [15:0] scr(input logic [15:0] w);
    return {w[15:1] ^ {15{w[0]}}, w[0]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic caps(input int n);
    repeat (n) begin
      @(posedge clk);
      while (capturedValid !== 1'b1) @(posedge clk);
    end
  endtask

  // enough captures to flush the pipeline and both synchronisers
  task automatic settle(input int a, input logic [31:0] ctl);
    logic [1:0] r;
    wr(CTRL_OFFSET, ctl, r);
    analogIn <= ANALOG_WIDTH'(a);
    caps(12);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    int a;
    int k;
    logic [15:0] e;
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(STATUS_OFFSET, d, r);
    chk(d, STATUS_RESET);
    rd(MASK_OFFSET, d, r);
    chk(d, MASK_RESET);
    rd(CTRL_OFFSET, d, r);
    chk(d, CTRL_RESET);
    chk(r, RESP_OKAY);
    wr(8'h40, 32'hFFFFFFFF, r);
    chk(r, RESP_SLVERR);
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      for (int s = 0; s < 2; s++) begin
        a = int'(rnd() & 32'h3FFE) - 8192;
        settle(a, (f << 5) | (s << 2));
        e = expCode(a, 1'b0) ^ ((f >= 2) ? 16'h8000 : 16'h0000);
        chk(heldCode, expCode(a, 1'b0));
        chk(capturedWord, e);
        chk(link.sampleWord, s ? scr(e) : e);
        chk(twosComplement, f >= 2);
        chk(stabilizerOn, f == 1 || f == 2);
        rd(DATA_OFFSET, d, r);
        chk(d, {16'h0, e});
      end
    end
    $display("test formats done");
    settle(2000, 32'h1 << CTRL_GAIN);
    chk(heldCode, expCode(2000, 1'b1));
    wr(MASK_OFFSET, 32'h2, r);
    chk(r, RESP_OKAY);
    wr(STATUS_OFFSET, 32'h3, r);
    caps(2);
    chk(irq, 1'b0);
    rd(STATUS_OFFSET, d, r);
    chk(d, 32'h00000001);
    settle(40000, 32'h0);
    chk(heldCode, 16'hFFFF);
    chk(capturedFlag, 1'b1);
    chk(irq, 1'b1);
    settle(-40000, 32'h0);
    chk(heldCode, 16'h0000);
    chk(heldOverRange, 1'b1);
    wr(MASK_OFFSET, 32'h0, r);
    caps(1);
    chk(irq, 1'b0);
    settle(0, 32'h0);
    chk(capturedFlag, 1'b0);
    chk(heldCode, 16'h8000);
    $display("test range done");
    a = int'(rnd() & 32'h3FFE);
    settle(a, 32'h0);
    e = expCode(a + 1000, 1'b0);
    analogIn <= ANALOG_WIDTH'(a + 1000);
    while (heldCode !== e) @(posedge clk);
    k = 0;
    while (link.sampleWord !== e && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk(k, LATENCY_CYCLES * 2 * LINK_HALF_CYCLES);
    $display("test latency done");
    settle(0, 32'h1 << CTRL_DITHER);
    chk(ditherActive, 1'b1);
    chk(heldCode >= 16'h7FFE && heldCode <= 16'h8001, 1'b1);
    k = 0;
    repeat (40) begin
      caps(1);
      if (heldCode !== 16'h8000) k++;
    end
    chk(k != 0, 1'b1);
    wr(CTRL_OFFSET, 32'h1, r);
    repeat (10) @(posedge clk);
    chk(poweredDown, 1'b1);
    chk(link.sampleWordOe, 1'b0);
    wr(CTRL_OFFSET, 32'h1 << CTRL_OUT_DISABLE, r);
    repeat (10) @(posedge clk);
    chk(poweredDown, 1'b0);
    chk(link.sampleWordOe, 1'b0);
    a = int'(rnd() & 32'h3FFE);
    settle(a, 32'h1 << CTRL_CAPTURE_ON_CLOCK);
    chk(link.sampleWordOe, 1'b1);
    chk(capturedWord, expCode(a, 1'b0));
    $display("test power and capture done");
    test_done();
  end
endmodule
